// file: hdl/wdt_watchdog_timer.sv
// Contract
// - Normal mode is a 16-bit load/count/reload timer on the 32.768 kHz clock, /1,/16,/256.
// - Capture the live count on an event while interrupt enable bit 5 is set.
// - Control bit 5 enters watchdog mode; left clear, the timer stays normal.
// - In watchdog mode the counter decrements from the reload value to zero.
// - Divide-by-256 with full-scale reload gives a 512 second timeout.
// - At zero in watchdog mode, interrupt if control bit 1 set, else reset.
// - Any kick write in watchdog mode reloads the counter, starting a new period.
// - A kick write in normal mode clears the timer interrupt unless a terminal tick sets it in the same cycle.
// - In watchdog mode reload and control writes are ignored until power-on reset.
// - Resets other than power-on leave the watchdog and counter running.
// - Counter stops while the debug port holds the core, resumes on release.
// - Peripheral power-down keeps counting unless control bit 0 is set.
// - Bit 8 counts up, bit 7 enables, bit 6 selects periodic over free-running.
// - Control bits 3:2 hold the prescale code; 00 divides by one.
// - Secure clear: only a kick equal to the LFSR state averts reset.
// - Seed comes from a kick before watchdog entry; later kicks compare to state.
// - A matching secure kick advances the LFSR as the counter reloads.
// - A mismatching secure kick resets at once, before the timeout.
// - In secure mode a kick of 0x00, or any kick after a 0x00 seed, forces an immediate reset.
// - The LFSR state cannot be read over the bus.
`timescale 1ns/1ps
`default_nettype none

module wdt_watchdog_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic oscClk,
  input wire logic captureEvent,
  input wire logic debugHalt,
  input wire logic irqEnableBit5,
  input wire logic periphPowerDown,
  input wire wdt_pkg::wdt_axi_req_s axiReq,
  output var wdt_pkg::wdt_axi_rsp_s axiRsp,
  output logic timerIrq,
  output logic wdtResetReq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] oscSync;
    logic oscPrev;
    logic [1:0] capSync;
    logic capPrev;
    logic [1:0] dbgSync;
    logic [7:0] preCount;
    logic [15:0] reload;
    logic [15:0] count;
    logic [15:0] capture;
    logic [wdt_pkg::CTL_WIDTH-1:0] ctrl;
    wdt_pkg::wdt_mode_e mode;
    logic [7:0] lfsr;
    logic irq;
    logic rstReq;
    logic awPend;
    logic [31:0] awAddr;
    logic wPend;
    logic [31:0] wData;
    logic [3:0] wStrb;
    wdt_pkg::wdt_axi_rsp_s rsp;
  } wdt_state_s;

  wdt_state_s cur;
  wdt_state_s next_cur;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Next expected secure kick value
  function automatic logic [7:0] lfsrAdvance(input logic [7:0] v);
    logic [7:0] shifted;
    shifted = {v[6:0], 1'b0};
    return v[7] ? (shifted ^ wdt_pkg::LFSR_TAPS) : shifted;
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Combinational next state
  // ----------------------------------------------------------------
  logic oscRise;
  logic capRise;
  logic tick;
  logic paused;
  logic running;
  logic [7:0] preLast;
  logic doWrite;
  logic kickReload;
  logic [15:0] newCtrl;

  always_comb begin
    next_cur = cur;
    oscRise = 1'b0;
    capRise = 1'b0;
    tick = 1'b0;
    paused = 1'b0;
    running = 1'b0;
    preLast = wdt_pkg::PRE_LAST1;
    doWrite = 1'b0;
    kickReload = 1'b0;
    newCtrl = 16'h0000;

    // Pin synchronisers; only the second stage feeds logic
    next_cur.oscSync = {cur.oscSync[0], oscClk};
    next_cur.oscPrev = cur.oscSync[1];
    next_cur.capSync = {cur.capSync[0], captureEvent};
    next_cur.capPrev = cur.capSync[1];
    next_cur.dbgSync = {cur.dbgSync[0], debugHalt};
    oscRise = cur.oscSync[1] & ~cur.oscPrev;
    capRise = cur.capSync[1] & ~cur.capPrev;

    // Reset request is a single-cycle pulse
    next_cur.rstReq = 1'b0;

    if (capRise && irqEnableBit5) begin
      next_cur.capture = cur.count;
    end

    // prescale select; reserved code 11 falls back to divide by one
    case (cur.ctrl[wdt_pkg::CTL_PRE_HI:wdt_pkg::CTL_PRE_LO])
      wdt_pkg::PRE_DIV16: begin
        preLast = wdt_pkg::PRE_LAST16;
      end
      wdt_pkg::PRE_DIV256: begin
        preLast = wdt_pkg::PRE_LAST256;
      end
      default: begin
        preLast = wdt_pkg::PRE_LAST1;
      end
    endcase

    // debug halt; optional stop in power-down
    paused = cur.dbgSync[1] ||
             (periphPowerDown && cur.ctrl[wdt_pkg::CTL_STOP_PD]);
    running = (cur.mode == wdt_pkg::MODE_WATCHDOG) || cur.ctrl[wdt_pkg::CTL_ENABLE];

    if (running && !paused && oscRise) begin
      if (cur.preCount >= preLast) begin
        next_cur.preCount = 8'h00;
        tick = 1'b1;
      end else begin
        next_cur.preCount = cur.preCount + 8'h01;
      end
    end

    // Bus write channel: address and data are taken in either order
    if (axiReq.awvalid && cur.rsp.awready) begin
      next_cur.awPend = 1'b1;
      next_cur.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && cur.rsp.wready) begin
      next_cur.wPend = 1'b1;
      next_cur.wData = axiReq.wdata;
      next_cur.wStrb = axiReq.wstrb;
    end
    if (cur.rsp.bvalid && axiReq.bready) begin
      next_cur.rsp.bvalid = 1'b0;
    end
    doWrite = cur.awPend && cur.wPend && !cur.rsp.bvalid;

    if (doWrite) begin
      next_cur.awPend = 1'b0;
      next_cur.wPend = 1'b0;
      next_cur.rsp.bvalid = 1'b1;
      next_cur.rsp.bresp = wdt_pkg::RESP_OKAY;
      case (cur.awAddr)
        wdt_pkg::ADDR_RELOAD: begin
          if (cur.mode == wdt_pkg::MODE_NORMAL) begin
            next_cur.reload = merge16(cur.reload, cur.wData, cur.wStrb);
          end
        end
        wdt_pkg::ADDR_CONTROL: begin
          if (cur.mode == wdt_pkg::MODE_NORMAL) begin
            newCtrl = merge16({7'h00, cur.ctrl}, cur.wData, cur.wStrb);
            next_cur.ctrl = newCtrl[wdt_pkg::CTL_WIDTH-1:0];
            // entry into watchdog mode starts from the reload value unless a tick in the same cycle steps the old count
            if (newCtrl[wdt_pkg::CTL_WD_MODE]) begin
              next_cur.mode = wdt_pkg::MODE_WATCHDOG;
              next_cur.count = cur.reload;
              next_cur.preCount = 8'h00;
            end
          end
        end
        wdt_pkg::ADDR_KICK: begin
          if (cur.mode == wdt_pkg::MODE_NORMAL) begin
            next_cur.irq = 1'b0;
            next_cur.lfsr = cur.wData[7:0];
            kickReload = 1'b1;
          end else if (cur.ctrl[wdt_pkg::CTL_SECURE]) begin
            // secure kick must match; zero never matches
            if (cur.wData[7:0] == cur.lfsr && cur.lfsr != wdt_pkg::LFSR_ZERO) begin
              next_cur.lfsr = lfsrAdvance(cur.lfsr);
              kickReload = 1'b1;
            end else begin
              next_cur.rstReq = 1'b1;
              kickReload = 1'b1;
            end
          end else begin
            kickReload = 1'b1;
          end
        end
        wdt_pkg::ADDR_COUNT, wdt_pkg::ADDR_CAPTURE: begin
          next_cur.rsp.bresp = wdt_pkg::RESP_OKAY;
        end
        default: begin
          next_cur.rsp.bresp = wdt_pkg::RESP_DECERR;
        end
      endcase
    end

    // Counter; a kick reload takes precedence over a tick
    if (kickReload) begin
      next_cur.count = cur.reload;
      next_cur.preCount = 8'h00;
      // A terminal tick in the clearing cycle still raises the flag: set beats clear
      if (tick && cur.mode == wdt_pkg::MODE_NORMAL &&
          cur.count == (cur.ctrl[wdt_pkg::CTL_COUNT_UP] ?
                        wdt_pkg::CNT_FULL : wdt_pkg::CNT_ZERO)) begin
        next_cur.irq = 1'b1;
      end
    end else if (tick) begin
      if (cur.mode == wdt_pkg::MODE_WATCHDOG) begin
        // down to zero; then interrupt or reset and restart
        if (cur.count == wdt_pkg::CNT_ZERO) begin
          if (cur.ctrl[wdt_pkg::CTL_IRQ_MODE]) begin
            next_cur.irq = 1'b1;
          end else begin
            next_cur.rstReq = 1'b1;
          end
          next_cur.count = cur.reload;
        end else begin
          next_cur.count = cur.count - wdt_pkg::CNT_ONE;
        end
      end else if (cur.ctrl[wdt_pkg::CTL_COUNT_UP]) begin
        // count up, wrap or reload past full scale
        if (cur.count == wdt_pkg::CNT_FULL) begin
          next_cur.irq = 1'b1;
          next_cur.count = cur.ctrl[wdt_pkg::CTL_PERIODIC] ? cur.reload : wdt_pkg::CNT_ZERO;
        end else begin
          next_cur.count = cur.count + wdt_pkg::CNT_ONE;
        end
      end else begin
        // count down, wrap or reload past zero
        if (cur.count == wdt_pkg::CNT_ZERO) begin
          next_cur.irq = 1'b1;
          next_cur.count = cur.ctrl[wdt_pkg::CTL_PERIODIC] ? cur.reload : wdt_pkg::CNT_FULL;
        end else begin
          next_cur.count = cur.count - wdt_pkg::CNT_ONE;
        end
      end
    end

    // Bus read channel; one outstanding read
    if (cur.rsp.rvalid && axiReq.rready) begin
      next_cur.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && cur.rsp.arready) begin
      next_cur.rsp.rvalid = 1'b1;
      next_cur.rsp.rresp = wdt_pkg::RESP_OKAY;
      next_cur.rsp.rdata = 32'h00000000;
      case (axiReq.araddr)
        wdt_pkg::ADDR_RELOAD: begin
          next_cur.rsp.rdata = {16'h0000, cur.reload};
        end
        wdt_pkg::ADDR_COUNT: begin
          next_cur.rsp.rdata = {16'h0000, cur.count};
        end
        wdt_pkg::ADDR_CONTROL: begin
          next_cur.rsp.rdata = {23'h000000, cur.ctrl};
        end
        wdt_pkg::ADDR_KICK: begin
          next_cur.rsp.rdata = 32'h00000000;
        end
        wdt_pkg::ADDR_CAPTURE: begin
          next_cur.rsp.rdata = {16'h0000, cur.capture};
        end
        default: begin
          next_cur.rsp.rresp = wdt_pkg::RESP_DECERR;
        end
      endcase
    end

    // Ready flags held in flops so that every output is registered
    next_cur.rsp.awready = !next_cur.awPend && !next_cur.rsp.bvalid;
    next_cur.rsp.wready = !next_cur.wPend && !next_cur.rsp.bvalid;
    next_cur.rsp.arready = !next_cur.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // rst_n is the power-on reset only; system resets do not reach here
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur <= '0;
      cur.reload <= wdt_pkg::RST_RELOAD;
      cur.count <= wdt_pkg::RST_COUNT;
      cur.ctrl <= wdt_pkg::RST_CONTROL;
      cur.lfsr <= wdt_pkg::RST_LFSR;
      cur.mode <= wdt_pkg::MODE_NORMAL;
      cur.rsp.awready <= 1'b1;
      cur.rsp.wready <= 1'b1;
      cur.rsp.arready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign axiRsp = cur.rsp;
  assign timerIrq = cur.irq;
  assign wdtResetReq = cur.rstReq;

endmodule

`default_nettype wire

// file: hdl/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_RELOAD = 32'hFFFF0360;
  localparam logic [31:0] ADDR_COUNT = 32'hFFFF0364;
  localparam logic [31:0] ADDR_CONTROL = 32'hFFFF0368;
  localparam logic [31:0] ADDR_KICK = 32'hFFFF036C;
  localparam logic [31:0] ADDR_CAPTURE = 32'hFFFF0370;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_RELOAD = 16'h03D7;
  localparam logic [15:0] RST_COUNT = 16'h03D7;
  localparam logic [8:0] RST_CONTROL = 9'h000;
  localparam logic [7:0] RST_LFSR = 8'h00;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_STOP_PD = 0;
  localparam int CTL_IRQ_MODE = 1;
  localparam int CTL_PRE_LO = 2;
  localparam int CTL_PRE_HI = 3;
  localparam int CTL_SECURE = 4;
  localparam int CTL_WD_MODE = 5;
  localparam int CTL_PERIODIC = 6;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_COUNT_UP = 8;
  localparam int CTL_WIDTH = 9;

  // ----------------------------------------------------------------
  // Prescaler codes and terminal counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV16 = 2'h1;
  localparam logic [1:0] PRE_DIV256 = 2'h2;
  localparam logic [7:0] PRE_LAST1 = 8'h00;
  localparam logic [7:0] PRE_LAST16 = 8'h0F;
  localparam logic [7:0] PRE_LAST256 = 8'hFF;

  // ----------------------------------------------------------------
  // Counter and sequence constants
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] LFSR_TAPS = 8'h63;
  localparam logic [7:0] LFSR_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Bus response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_WATCHDOG = 1'b1
  } wdt_mode_e;

  // Master to slave signals of the register bus
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } wdt_axi_req_s;

  // Slave to master signals of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdt_axi_rsp_s;

endpackage

// file: tb/wdt_watchdog_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module wdt_watchdog_timer_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire wdt_pkg::wdt_axi_req_s axiReq,
  input wire wdt_pkg::wdt_axi_rsp_s axiRsp,
  input wire logic timerIrq,
  input wire logic wdtResetReq
);
  // ----------------------------------------------------------------
  // Bus handshake and output pulse checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic unmapped;

  // Read address outside the decoded words
  assign unmapped = !(axiReq.araddr inside {wdt_pkg::ADDR_RELOAD, wdt_pkg::ADDR_COUNT,
    wdt_pkg::ADDR_CONTROL, wdt_pkg::ADDR_KICK, wdt_pkg::ADDR_CAPTURE});

  reset_idle_a: assert property ($rose(rst_n) |-> axiRsp.awready && axiRsp.arready
    && !axiRsp.bvalid && !axiRsp.rvalid && !timerIrq && !wdtResetReq)
    else $error("bus or outputs not idle after reset");
  // Both channels taken at one edge: write lands at the next, bvalid seen one after
  wr_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |=> ##1 axiRsp.bvalid)
    else $error("write response late");
  b_busy_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write accepted while response pending");
  rd_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read data late");
  r_busy_a: assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read accepted while data pending");
  // Holes in the map must answer with an error and zero data
  rd_decerr_a: assert property (axiReq.arvalid && axiRsp.arready && unmapped
    |=> axiRsp.rresp == wdt_pkg::RESP_DECERR && axiRsp.rdata == 32'h00000000)
    else $error("unmapped read not refused");
  rst_pulse_a: assert property (wdtResetReq |=> !wdtResetReq)
    else $error("reset request longer than one cycle");
  irq_clear_a: assert property ($fell(timerIrq) |-> axiRsp.bvalid)
    else $error("interrupt dropped without a write");
endmodule

bind wdt_watchdog_timer wdt_watchdog_timer_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .axiReq(axiReq), .axiRsp(axiRsp), .timerIrq(timerIrq), .wdtResetReq(wdtResetReq));

`default_nettype wire

// file: tb/wdt_watchdog_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module wdt_watchdog_timer_tb;
  // ----------------------------------------------------------------
  // Stimulus signals and the design
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic oscClk = 1'b0;
  logic captureEvent = 1'b0;
  logic debugHalt = 1'b0;
  logic irqEnableBit5 = 1'b0;
  logic periphPowerDown = 1'b0;
  wdt_pkg::wdt_axi_req_s axiReq = '0;
  wdt_pkg::wdt_axi_rsp_s axiRsp;
  logic timerIrq;
  logic wdtResetReq;
  int miscompares = 0;
  int nChecks = 0;
  int rstPulses = 0;
  logic [7:0] expKick;

  wdt_watchdog_timer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .oscClk(oscClk),
    .captureEvent(captureEvent), .debugHalt(debugHalt), .irqEnableBit5(irqEnableBit5),
    .periphPowerDown(periphPowerDown), .axiReq(axiReq), .axiRsp(axiRsp),
    .timerIrq(timerIrq), .wdtResetReq(wdtResetReq));

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  // Count reset request pulses seen on the output
  always @(posedge clk_sys) begin
    if (wdtResetReq === 1'b1) rstPulses <= rstPulses + 1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic printVerdict();
    if (miscompares == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask

  // Write with both channels offered together; bready held until the answer
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) break;
    end
    axiReq.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, axiRsp.bresp});
    // Let an edge pass so a following call never re-drives bready in this step
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) break;
    end
    axiReq.rready <= 1'b0;
    chk(n, e, axiRsp.rdata);
    chk("rresp", {30'h0, er}, {30'h0, axiRsp.rresp});
    // Let an edge pass so a following call never re-drives rready in this step
    @(posedge clk_sys);
  endtask

  // Oscillator edges spaced wide enough for the two-stage synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      oscClk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      oscClk <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic pulses(input int e);
    repeat (2) @(posedge clk_sys);
    chk("reset pulses", e, rstPulses);
  endtask

  task automatic irq(input logic e);
    repeat (2) @(posedge clk_sys);
    chk("timerIrq", {31'h0, e}, {31'h0, timerIrq});
  endtask

  // Software model of the secure sequence
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], 1'b0} ^ (x[7] ? 8'h63 : 8'h00);
  endfunction

  // Watchdog on the whole run; the tests take about fourteen thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    miscompares++;
    printVerdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc("reload", wdt_pkg::ADDR_RELOAD, 32'h000003D7, wdt_pkg::RESP_OKAY);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h000003D7, wdt_pkg::RESP_OKAY);
    rdc("control", wdt_pkg::ADDR_CONTROL, 32'h00000000, wdt_pkg::RESP_OKAY);
    rdc("kick", wdt_pkg::ADDR_KICK, 32'h00000000, wdt_pkg::RESP_OKAY);
    rdc("hole", 32'hFFFF0374, 32'h00000000, wdt_pkg::RESP_DECERR);
    wr(32'hFFFF0378, 32'h00000001, wdt_pkg::RESP_DECERR);
    // Normal mode counting, direction and prescale
    wr(wdt_pkg::ADDR_RELOAD, 32'h00000010, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h000000AA, wdt_pkg::RESP_OKAY);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h00000010, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000080, wdt_pkg::RESP_OKAY);
    tick(3);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000D, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000180, wdt_pkg::RESP_OKAY);
    tick(2);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000F, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000084, wdt_pkg::RESP_OKAY);
    tick(16);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000E, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000088, wdt_pkg::RESP_OKAY);
    tick(256);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000D, wdt_pkg::RESP_OKAY);
    // Debug halt and power-down stop
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000080, wdt_pkg::RESP_OKAY);
    debugHalt <= 1'b1;
    tick(3);
    debugHalt <= 1'b0;
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000D, wdt_pkg::RESP_OKAY);
    periphPowerDown <= 1'b1;
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000081, wdt_pkg::RESP_OKAY);
    tick(2);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000D, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000080, wdt_pkg::RESP_OKAY);
    tick(2);
    periphPowerDown <= 1'b0;
    wr(wdt_pkg::ADDR_COUNT, 32'h00001234, wdt_pkg::RESP_OKAY);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000000B, wdt_pkg::RESP_OKAY);
    // Capture of a frozen count, then interrupt and clear
    irqEnableBit5 <= 1'b1;
    captureEvent <= 1'b1;
    repeat (4) @(posedge clk_sys);
    captureEvent <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc("capture", wdt_pkg::ADDR_CAPTURE, 32'h0000000B, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_RELOAD, 32'h00000002, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h000000AA, wdt_pkg::RESP_OKAY);
    tick(3);
    irq(1'b1);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h0000FFFF, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h000000AA, wdt_pkg::RESP_OKAY);
    irq(1'b0);
    // Periodic mode reloads instead of wrapping
    wr(wdt_pkg::ADDR_CONTROL, 32'h000000C0, wdt_pkg::RESP_OKAY);
    tick(3);
    rdc("count", wdt_pkg::ADDR_COUNT, 32'h00000002, wdt_pkg::RESP_OKAY);
    irq(1'b1);
    // Secure watchdog: the seed is the last kick before entry
    // Timeout of 993 oscillator periods stays above the 30 ms floor
    wr(wdt_pkg::ADDR_RELOAD, 32'h000003E0, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h000000AA, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000030, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000000, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_RELOAD, 32'h00000005, wdt_pkg::RESP_OKAY);
    rdc("control", wdt_pkg::ADDR_CONTROL, 32'h00000030, wdt_pkg::RESP_OKAY);
    rdc("reload", wdt_pkg::ADDR_RELOAD, 32'h000003E0, wdt_pkg::RESP_OKAY);
    expKick = 8'hAA;
    repeat (3) begin
      tick(2);
      wr(wdt_pkg::ADDR_KICK, {24'h0, expKick}, wdt_pkg::RESP_OKAY);
      pulses(0);
      rdc("count", wdt_pkg::ADDR_COUNT, 32'h000003E0, wdt_pkg::RESP_OKAY);
      expKick = nxt(expKick);
    end
    chk("sequence", 32'h000000DC, {24'h0, expKick});
    wr(wdt_pkg::ADDR_KICK, 32'h00000066, wdt_pkg::RESP_OKAY);
    pulses(1);
    tick(992);
    pulses(1);
    tick(1);
    pulses(2);
    // Power-on reset lifts the lock; a zero seed always fails
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc("control", wdt_pkg::ADDR_CONTROL, 32'h00000000, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h00000000, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_RELOAD, 32'h000003E0, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_CONTROL, 32'h00000032, wdt_pkg::RESP_OKAY);
    wr(wdt_pkg::ADDR_KICK, 32'h00000000, wdt_pkg::RESP_OKAY);
    pulses(3);
    tick(992);
    irq(1'b0);
    tick(1);
    irq(1'b1);
    pulses(3);
    printVerdict();
  end
endmodule

`default_nettype wire
